/* File: src/pbwg_pkg.sv */
// Operation
// - in mode 11, protected bits ignore writes unless access open
// - mode 11: open code 10011 opens access
// - mode 11: close code 10101 closes access
// - open/close writes never change the mode
// - mode changes only with pass code 11000 or byte D0
// - byte D0 disables the protection scheme
// - open window lasts at most 32 cycles
// - repeated open code restarts the window
// - guards dividers, watchdog, power-down, slow-down enables
`default_nettype none
package pbwg_pkg;
  // bus map, byte addresses
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  OFS_PASSWORD   = 4'h0;
  localparam logic [3:0]  OFS_CLK_DIV    = 4'h4;
  localparam logic [3:0]  OFS_PWR_CTRL   = 4'h8;
  // password register layout
  localparam int          PASS_HI        = 7;
  localparam int          PASS_LO        = 3;
  localparam int          STAT_BIT       = 2;
  localparam int          MODE_HI        = 1;
  localparam int          MODE_LO        = 0;
  localparam logic [4:0]  CODE_OPEN      = 5'h13;
  localparam logic [4:0]  CODE_CLOSE     = 5'h15;
  localparam logic [4:0]  CODE_MODE      = 5'h18;
  localparam logic [7:0]  BYTE_DISABLE   = 8'hD0;
  localparam logic [1:0]  MODE_PROTECT   = 2'h3;
  localparam logic [1:0]  MODE_RESET     = 2'h3;
  localparam logic [1:0]  MODE_OFF       = 2'h0;
  // divider register layout
  localparam int          FEEDBACK_DIVIDER_FIELD_HI        = 3;
  localparam int          FEEDBACK_DIVIDER_FIELD_LO        = 0;
  localparam int          OUTPUT_DIVIDER_FIELD_HI        = 7;
  localparam int          OUTPUT_DIVIDER_FIELD_LO        = 4;
  localparam logic [3:0]  FEEDBACK_DIVIDER_FIELD_RESET     = 4'h0;
  localparam logic [3:0]  OUTPUT_DIVIDER_FIELD_RESET     = 4'h0;
  // power control layout
  localparam int          WDT_BIT        = 0;
  localparam int          PD_BIT         = 1;
  localparam int          SD_BIT         = 2;
  localparam logic [2:0]  PWR_RESET      = 3'h0;
  // open window length in core cycles
  localparam int          WIN_CYCLES     = 32;
  localparam int          WIN_W          = 6;
  localparam logic [5:0]  WIN_LOAD       = 6'(WIN_CYCLES);
  localparam logic [5:0]  WIN_ZERO       = 6'h00;
  localparam logic [5:0]  WIN_STEP       = 6'h01;
endpackage
`default_nettype wire

/* File: src/pbwg_open_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module pbwg_open_timer
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // control
  input  wire logic open_in,
  input  wire logic close_in,
  // status
  output var  logic open_out
);
  logic [pbwg_pkg::WIN_W-1:0] count_reg;
  logic [pbwg_pkg::WIN_W-1:0] count_next;
  wire  logic                 running;

  assign running  = (count_reg != pbwg_pkg::WIN_ZERO);
  assign open_out = running;

  always_comb
  begin
    count_next = count_reg;
    if (close_in)
      count_next = pbwg_pkg::WIN_ZERO;
    else if (open_in)
      count_next = pbwg_pkg::WIN_LOAD;
    else if (running)
      count_next = count_reg - pbwg_pkg::WIN_STEP;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      count_reg <= pbwg_pkg::WIN_ZERO;
    else if (ce_in)
      count_reg <= count_next;
  end
endmodule
`default_nettype wire

/* File: src/pbwg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pbwg_top
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output var  logic [31:0] avs_readdata_out,
  output var  logic        avs_waitrequest_out,
  // protected control fields
  output var  logic [3:0]  feedback_divider_field_out,
  output var  logic [3:0]  output_divider_field_out,
  output var  logic        watchdog_enable_bit_out,
  output var  logic        power_down_enable_bit_out,
  output var  logic        slow_down_enable_bit_out,
  // protection status
  output var  logic        access_open_out,
  output var  logic [1:0]  protect_mode_out
);
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  mode_reg;
  logic [1:0]  mode_next;
  logic [3:0]  feedback_divider_field_reg;
  logic [3:0]  output_divider_field_reg;
  logic [2:0]  pwr_reg;

  wire  logic       req;
  wire  logic       wr_go;
  wire  logic       rd_first;
  wire  logic       lane0;
  wire  logic [7:0] wbyte;
  wire  logic [4:0] pass;
  wire  logic       sel_pw;
  wire  logic       sel_div;
  wire  logic       sel_pwr;
  wire  logic       protect_on;
  wire  logic       win_open;
  wire  logic       open_cmd;
  wire  logic       close_cmd;
  wire  logic       mode_cmd;
  wire  logic       disable_cmd;
  wire  logic       may_write;
  wire  logic [7:0] pw_view;
  wire  logic [7:0] div_view;
  wire  logic [7:0] pwr_view;
  wire  logic [7:0] rd_byte;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // one wait state per access
  assign req                 = avs_read_in | avs_write_in;
  // answer only on an enabled edge, else the access keeps waiting
  assign avs_waitrequest_out = req & ~(ack_reg & ce_in);
  assign rd_first            = avs_read_in & ~ack_reg;
  assign wr_go               = avs_write_in & ack_reg & ce_in;
  assign avs_readdata_out    = rdata_reg;

  assign lane0   = avs_byteenable_in[0];
  assign wbyte   = avs_writedata_in[7:0];
  assign pass    = wbyte[pbwg_pkg::PASS_HI:pbwg_pkg::PASS_LO];
  assign sel_pw  = hit(avs_address_in, pbwg_pkg::OFS_PASSWORD);
  assign sel_div = hit(avs_address_in, pbwg_pkg::OFS_CLK_DIV);
  assign sel_pwr = hit(avs_address_in, pbwg_pkg::OFS_PWR_CTRL);

  assign protect_on  = (mode_reg == pbwg_pkg::MODE_PROTECT);
  assign open_cmd    = wr_go & lane0 & sel_pw & protect_on
                     & (pass == pbwg_pkg::CODE_OPEN);
  assign close_cmd   = wr_go & lane0 & sel_pw & protect_on
                     & (pass == pbwg_pkg::CODE_CLOSE);
  assign mode_cmd    = wr_go & lane0 & sel_pw
                     & (pass == pbwg_pkg::CODE_MODE);
  assign disable_cmd = wr_go & lane0 & sel_pw
                     & (wbyte == pbwg_pkg::BYTE_DISABLE);

  assign may_write = ~protect_on | win_open;

  pbwg_open_timer u_timer
  (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .open_in  (open_cmd),
    .close_in (close_cmd),
    .open_out (win_open)
  );

  always_comb
  begin
    mode_next = mode_reg;
    if (mode_cmd)
      mode_next = wbyte[pbwg_pkg::MODE_HI:pbwg_pkg::MODE_LO];
    else if (disable_cmd)
      mode_next = pbwg_pkg::MODE_OFF;
  end

  assign pw_view  = {5'h00, ~win_open, mode_reg};
  assign div_view = {output_divider_field_reg, feedback_divider_field_reg};
  assign pwr_view = {5'h00, pwr_reg};
  assign rd_byte  = sel_pw  ? pw_view  :
                    sel_div ? div_view :
                    sel_pwr ? pwr_view : 8'h00;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else if (ce_in)
    begin
      ack_reg <= req & ~ack_reg;
      if (rd_first)
        rdata_reg <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      mode_reg <= pbwg_pkg::MODE_RESET;
    else if (ce_in)
      mode_reg <= mode_next;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      feedback_divider_field_reg <= pbwg_pkg::FEEDBACK_DIVIDER_FIELD_RESET;
      output_divider_field_reg <= pbwg_pkg::OUTPUT_DIVIDER_FIELD_RESET;
    end
    else if (wr_go & lane0 & sel_div & may_write)
    begin
      feedback_divider_field_reg <= wbyte[pbwg_pkg::FEEDBACK_DIVIDER_FIELD_HI:pbwg_pkg::FEEDBACK_DIVIDER_FIELD_LO];
      output_divider_field_reg <= wbyte[pbwg_pkg::OUTPUT_DIVIDER_FIELD_HI:pbwg_pkg::OUTPUT_DIVIDER_FIELD_LO];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pwr_reg <= pbwg_pkg::PWR_RESET;
    else if (wr_go & lane0 & sel_pwr & may_write)
      pwr_reg <= wbyte[pbwg_pkg::SD_BIT:pbwg_pkg::WDT_BIT];
  end

  assign feedback_divider_field_out = feedback_divider_field_reg;
  assign output_divider_field_out   = output_divider_field_reg;
  assign watchdog_enable_bit_out    = pwr_reg[pbwg_pkg::WDT_BIT];
  assign power_down_enable_bit_out  = pwr_reg[pbwg_pkg::PD_BIT];
  assign slow_down_enable_bit_out   = pwr_reg[pbwg_pkg::SD_BIT];
  assign access_open_out            = win_open;
  assign protect_mode_out           = mode_reg;
endmodule
`default_nettype wire

/* File: testbench/pbwg_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pbwg_properties
(
  // clock and bus
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic        avs_waitrequest_out,
  // guarded state
  input wire logic [3:0]  feedback_divider_field_out,
  input wire logic [3:0]  output_divider_field_out,
  input wire logic        watchdog_enable_bit_out,
  input wire logic        power_down_enable_bit_out,
  input wire logic        slow_down_enable_bit_out,
  input wire logic        access_open_out,
  input wire logic [1:0]  protect_mode_out
);
  wire logic [7:0] wbyte = avs_writedata_in[7:0];
  wire logic [4:0] code = avs_writedata_in[7:3];
  wire logic       take = avs_write_in & ~avs_waitrequest_out & ce_in
                          & avs_byteenable_in[0];
  wire logic       pw = take & (avs_address_in == 4'h0);
  wire logic       gw = take & (avs_address_in inside {4'h4, 4'h8});
  wire logic       dv = take & (avs_address_in == 4'h4);
  wire logic       on = protect_mode_out == 2'h3;
  wire logic [7:0] divs = {output_divider_field_out,
                           feedback_divider_field_out};
  wire logic [2:0] pwrs = {slow_down_enable_bit_out,
                           power_down_enable_bit_out,
                           watchdog_enable_bit_out};
  logic [5:0]      run_reg;
  logic [7:0]      byte_reg;
  // cycles since the window last opened
  always_ff @(posedge clk_in)
  begin
    byte_reg <= wbyte;
    if (rst_in || (pw && code == 5'h13) || !access_open_out)
      run_reg <= 6'h00;
    else if (ce_in)
      run_reg <= run_reg + 6'h01;
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_open_grants:
    assert property (pw && on && code == 5'h13 |=> access_open_out)
    else $error("open code left access shut");
  a_close_shuts:
    assert property (pw && on && code == 5'h15 |=> !access_open_out)
    else $error("close code left access open");
  a_mode_kept:
    assert property (pw && code != 5'h18 && wbyte != 8'hD0
      |=> $stable(protect_mode_out)) else $error("mode changed");
  a_mode_loads:
    assert property (pw && code == 5'h18
      |=> protect_mode_out == byte_reg[1:0]) else $error("mode not loaded");
  a_disable_byte:
    assert property (pw && wbyte == 8'hD0 |=> protect_mode_out == 2'h0)
    else $error("scheme not disabled");
  a_window_bound:
    assert property (access_open_out |-> run_reg < 6'h20)
    else $error("window longer than limit");
  a_closed_guard:
    assert property (gw && on && !access_open_out |=> $stable({divs, pwrs}))
    else $error("guarded bits changed while shut");
  a_free_write:
    assert property (dv && (!on || access_open_out) |=> divs == byte_reg)
    else $error("allowed divider write lost");
endmodule
bind pbwg_top pbwg_properties i_props
(
  .clk_in, .rst_in, .ce_in, .avs_address_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out,
  .feedback_divider_field_out, .output_divider_field_out,
  .watchdog_enable_bit_out, .power_down_enable_bit_out,
  .slow_down_enable_bit_out, .access_open_out, .protect_mode_out
);
`default_nettype wire

/* File: testbench/test_protected_bit_write_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module test_protected_bit_write_gate;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h00000000;
  logic        ce = 1'b1;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdata, got, n;
  logic [3:0]  feedback_divider_field, output_divider_field;
  logic        wt, wdt, pdn, slo, opn;
  logic [1:0]  mode;
  int          error_cnt = 0, num_checks = 0, cyc = 0;
  wire logic [19:0] st = {3'h0, opn, 2'h0, mode, output_divider_field, feedback_divider_field,
                          1'h0, slo, pdn, wdt};
  // address, byte, then open, mode, dividers, power bits
  logic [31:0] rows [13] = '{32'h4A503000, 32'h80703000, 32'h09813000,
    32'h4A513A50, 32'h80513A55, 32'h0A803A55, 32'h43C03A55, 32'h0D000A55,
    32'h43C003C5, 32'h098003C5, 32'h0C3033C5, 32'h01A033C5, 32'hC55033C5};
  pbwg_top i_dut
  (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
    .feedback_divider_field_out(feedback_divider_field), .output_divider_field_out(output_divider_field),
    .watchdog_enable_bit_out(wdt), .power_down_enable_bit_out(pdn),
    .slow_down_enable_bit_out(slo), .access_open_out(opn),
    .protect_mode_out(mode)
  );
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic check(input string nm, input logic [31:0] e, s);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic r);
    @(posedge clk_in);
    adr <= a;
    wd <= {24'h000000, d};
    rd <= r;
    wr <= !r;
    do @(posedge clk_in); while (wt !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic do_reset;
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    check("reset state", 32'h00003000, {12'h000, st});
    $display("test reset done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      bus(rows[i][31:28], rows[i][27:20], 1'b0);
      @(negedge clk_in);
      check("state", {12'h000, rows[i][19:0]}, {12'h000, st});
    end
    $display("test table done");
    @(posedge clk_in);
    be <= 4'hE;
    bus(4'h0, 8'hD0, 1'b0);
    @(negedge clk_in);
    check("lane0 off mode", 32'h00000003, {30'h0, mode});
    @(posedge clk_in);
    be <= 4'hF;
    $display("test lanes done");
    bus(4'h4, 8'h00, 1'b1);
    check("divider read", 32'h0000003C, got);
    bus(4'hC, 8'h00, 1'b1);
    check("unmapped read", 32'h00000000, got);
    bus(4'h0, 8'h00, 1'b1);
    check("password read", 32'h00000007, got);
    $display("test reads done");
    bus(4'h0, 8'h98, 1'b0);
    repeat (20) @(posedge clk_in);
    bus(4'h0, 8'h98, 1'b0);
    n = 32'h00000000;
    @(negedge clk_in);
    while (opn === 1'b1)
    begin
      n++;
      @(negedge clk_in);
    end
    check("window cycles", 32'h00000020, n);
    $display("test window done");
    bus(4'h0, 8'h98, 1'b0);
    ce <= 1'b0;
    repeat (40) @(posedge clk_in);
    ce <= 1'b1;
    n = 32'h00000000;
    @(negedge clk_in);
    while (opn === 1'b1)
    begin
      n++;
      @(negedge clk_in);
    end
    check("frozen window", 32'h00000020, n);
    $display("test freeze done");
    do_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
